// >>> src/ddc_drive_ctrl.v
// Discrete output drive channel with APB configuration.
// Assumes an APB master on the core clock; port_o goes to an output driver.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "ddc_map.vh"

//Contract
// [R1] Linked value drives output when linked
// [R2] Unlinked: only assert/deassert commands decide
// [R3] Assert drives on for hold, overriding link
// [R4] Deassert command forces output off
// [R5] Resume hands control back to link
// [R6] Deassert/resume honoured only at zero hold
// [R7] Selectable inversion at output port
// [R8] Hold programmable 0..2,000,000 seconds
// [R9] Zero hold keeps assert on indefinitely
// [R10] Seconds tick timing; reassert restarts count
module ddc_drive_ctrl #(
	parameter [24:0] TICK_CYC = `DDC_TICK_CYC
) (
	// Clock and reset
	input  wire        core_clk_i,
	input  wire        rst_i,
	// APB slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	// Linked drive value from the system
	input  wire        link_value_i,
	// Output port
	output reg         port_o
);
	reg                    link_en_q;
	reg                    sw_value_q;
	reg                    invert_q;
	reg  [`DDC_HOLD_W-1:0] hold_q;
	reg  [`DDC_HOLD_W-1:0] remain_q;
	reg                    latch_q;
	reg                    forced_off_q;
	reg                    level_q;
	wire                   tick;
	wire                   setup;
	wire                   wr;
	wire                   cmd_wr;
	wire                   do_assert;
	wire                   do_deassert;
	wire                   do_resume;
	wire                   hold_zero;
	wire                   sel_ctrl;
	wire                   sel_hold;
	wire                   sel_cmd;
	wire                   timed_out;
	reg                    level_d;
	reg                    port_d;
	reg                    addr_ok;
	reg  [31:0]            rdata_d;
	reg  [`DDC_HOLD_W-1:0] hold_d;
	reg  [`DDC_HOLD_W-1:0] remain_d;
	reg                    latch_d;
	reg                    forced_off_d;

	// Zero wait: answer in the access cycle
	assign setup   = psel_i & ~penable_i;
	assign wr      = psel_i & penable_i & pwrite_i & pready_o;
	// Register selects, exact word offsets only
	assign sel_ctrl = (paddr_i == `DDC_OFF_CTRL);
	assign sel_hold = (paddr_i == `DDC_OFF_HOLD);
	assign sel_cmd  = (paddr_i == `DDC_OFF_CMD);
	assign cmd_wr  = wr & sel_cmd;
	assign do_assert   = cmd_wr & pwdata_i[`DDC_CMD_ASSERT];
	assign hold_zero   = (hold_q == `DDC_HOLD_RST);
	assign do_deassert = cmd_wr & pwdata_i[`DDC_CMD_DEASSERT] & hold_zero; // [R6]
	assign do_resume   = cmd_wr & pwdata_i[`DDC_CMD_RESUME] & hold_zero;   // [R6]
	// A zero count never matches, so zero hold stays on
	assign timed_out = latch_q & tick & (remain_q == `DDC_HOLD_W'd1); // [R9]

	// Restart keeps the first second of a pulse whole
	ddc_tick_gen #(
		.DIV       (TICK_CYC)
	) u_tick (
		.core_clk_i(core_clk_i),
		.rst_i     (rst_i),
		.restart_i (do_assert),
		.tick_o    (tick)
	);

	always @* begin
		case (paddr_i)
			`DDC_OFF_CTRL: addr_ok = 1'b1;
			`DDC_OFF_HOLD: addr_ok = 1'b1;
			`DDC_OFF_CMD:  addr_ok = 1'b1;
			`DDC_OFF_STAT: addr_ok = 1'b1;
			`DDC_OFF_REM:  addr_ok = 1'b1;
			default:       addr_ok = 1'b0;
		endcase
	end

	// Read word; the command register always reads zero
	always @* begin
		case (paddr_i)
			`DDC_OFF_CTRL: rdata_d = {29'h0000_0000, invert_q, sw_value_q, link_en_q};
			`DDC_OFF_HOLD: rdata_d = {11'h000, hold_q};
			`DDC_OFF_STAT: rdata_d = {29'h0000_0000, level_q, latch_q, port_o};
			`DDC_OFF_REM:  rdata_d = {11'h000, remain_q};
			default:       rdata_d = 32'h0000_0000;
		endcase
	end

	// Values above the range saturate rather than wrap
	always @* begin
		hold_d = hold_q;
		if (wr && sel_hold) begin
			if (pwdata_i > {11'h000, `DDC_HOLD_MAX})
				hold_d = `DDC_HOLD_MAX;             // [R8]
			else
				hold_d = pwdata_i[`DDC_HOLD_W-1:0]; // [R8]
		end
	end

	// APB response: one wait-free access cycle
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= setup;
			pslverr_o <= setup & ~addr_ok;
			if (setup && !pwrite_i)
				prdata_o <= rdata_d;
			else
				prdata_o <= 32'h0000_0000;
		end
	end

	// Configuration registers; writes land on the access edge
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			link_en_q  <= 1'b0;
			sw_value_q <= 1'b0;
			invert_q   <= 1'b0;
			hold_q     <= `DDC_HOLD_RST;
		end else begin
			if (wr && sel_ctrl) begin
				link_en_q  <= pwdata_i[`DDC_CTRL_LINK];
				sw_value_q <= pwdata_i[`DDC_CTRL_VALUE];
				invert_q   <= pwdata_i[`DDC_CTRL_INVERT];
			end
			hold_q <= hold_d;
		end
	end

	// Assert beats deassert beats resume beats timeout
	always @* begin
		latch_d      = latch_q;
		forced_off_d = forced_off_q;
		remain_d     = remain_q;
		if (do_assert) begin
			latch_d      = 1'b1;   // [R3]
			forced_off_d = 1'b0;
			remain_d     = hold_q; // [R10]
		end else if (do_deassert) begin
			latch_d      = 1'b0;
			forced_off_d = 1'b1;   // [R4]
		end else if (do_resume) begin
			latch_d      = 1'b0;   // [R5]
			forced_off_d = 1'b0;   // [R5]
		end else if (latch_q && tick) begin
			// Running count ignores later hold writes
			if (timed_out) begin
				latch_d  = 1'b0;
				remain_d = `DDC_HOLD_RST;
			end else if (remain_q != `DDC_HOLD_RST) begin
				remain_d = remain_q - `DDC_HOLD_W'd1; // [R10]
			end
		end
	end

	// Drive state: assert latch, forced-off and hold count
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			latch_q      <= 1'b0;
			forced_off_q <= 1'b0;
			remain_q     <= `DDC_HOLD_RST;
		end else begin
			latch_q      <= latch_d;
			forced_off_q <= forced_off_d;
			remain_q     <= remain_d;
		end
	end

	// Latch first, then link, otherwise off
	always @* begin
		if (latch_q)
			level_d = 1'b1;         // [R3]
		else if (link_en_q && !forced_off_q)
			level_d = link_value_i; // [R1]
		else if (!link_en_q)
			level_d = 1'b0;         // [R2]
		else
			level_d = 1'b0;         // [R4]
	end

	// Inversion last, so the status level stays uninverted
	always @* begin
		port_d = level_d ^ invert_q; // [R7]
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			level_q <= 1'b0;
			port_o  <= 1'b0;
		end else begin
			level_q <= level_d;
			port_o  <= port_d;
		end
	end

endmodule // ddc_drive_ctrl

// >>> inc/ddc_map.vh
// Register map, field layout and timing counts of the output drive block.
// Assumes a 20 MHz core clock and a 32-bit APB slave port.
`ifndef DDC_MAP_VH
`define DDC_MAP_VH

`define DDC_ADDR_W        12
`define DDC_OFF_CTRL      12'h000
`define DDC_OFF_HOLD      12'h004
`define DDC_OFF_CMD       12'h008
`define DDC_OFF_STAT      12'h00C
`define DDC_OFF_REM       12'h010

// Control fields
`define DDC_CTRL_LINK     0
`define DDC_CTRL_VALUE    1
`define DDC_CTRL_INVERT   2
`define DDC_CTRL_RST      32'h0000_0000

// Command fields, write one to fire
`define DDC_CMD_ASSERT    0
`define DDC_CMD_DEASSERT  1
`define DDC_CMD_RESUME    2

// Status fields
`define DDC_STAT_PORT     0
`define DDC_STAT_LATCH    1
`define DDC_STAT_LEVEL    2

`define DDC_HOLD_W        21
`define DDC_HOLD_MAX      21'h1E_8480
`define DDC_HOLD_RST      21'h00_0000

// Core clock cycles in one second at 20 MHz
`define DDC_TICK_CYC      25'h131_2D00
`define DDC_TICK_W        25

`endif

// >>> src/ddc_tick_gen.v
// One-second tick divider for the output drive block.
// Assumes the core clock rate given by the divide parameter.
`timescale 1ns/1ps
module ddc_tick_gen #(
	parameter [24:0] DIV = 25'h131_2D00
) (
	// Clock and reset
	input  wire        core_clk_i,
	input  wire        rst_i,
	// Restart aligns the second to a new pulse
	input  wire        restart_i,
	output reg         tick_o
);
	reg  [24:0] cnt_q;

	always @(posedge core_clk_i) begin
		if (rst_i || restart_i) begin
			cnt_q  <= 25'h000_0000;
			tick_o <= 1'b0;
		end else if (cnt_q == DIV - 25'd1) begin
			cnt_q  <= 25'h000_0000;
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 25'd1;
			tick_o <= 1'b0;
		end
	end
endmodule // ddc_tick_gen

// >>> tb/ddc_load.sv
// Far-side relay model.
// Coil driven by the drive port.
`timescale 1ns/1ps
module ddc_load (
	input  wire core_clk_i,
	input  wire drive_i,
	output reg  on_o
);
	// Contacts settle a cycle late
	always @(posedge core_clk_i) on_o <= drive_i;
endmodule // ddc_load

// >>> tb/ddc_drive_ctrl_sva.sv
// Port checker, drive block.
// Bound onto ddc_drive_ctrl.
`timescale 1ns/1ps
module ddc_chk (
	input wire        core_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, port_o,
	input wire [11:0] paddr_i,
	input wire [31:0] prdata_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	wire su = psel_i && !penable_i;
	property p_rdy; su |=> pready_o; endproperty
	property p_one; pready_o |=> !pready_o; endproperty
	property p_err; pslverr_o |-> pready_o; endproperty
	property p_unm; su && paddr_i > 12'h010 |=> pslverr_o; endproperty
	property p_cmd; su && !pwrite_i && paddr_i == 12'h008 |=> prdata_o == 32'h0; endproperty
	property p_hld; su && !pwrite_i && paddr_i == 12'h004 |=> prdata_o <= 32'h001E_8480; endproperty
	property p_sta; su && !pwrite_i && paddr_i == 12'h00C ##1 $stable(port_o) |-> prdata_o[0] == port_o; endproperty
	property p_rst; disable iff (1'b0) rst_i |=> !port_o && !pready_o; endproperty
	a_rdy: assert property (p_rdy) else $error("late ready");
	a_one: assert property (p_one) else $error("long ready");
	a_err: assert property (p_err) else $error("stray error");
	a_unm: assert property (p_unm) else $error("no error");
	a_cmd: assert property (p_cmd) else $error("cmd not 0");
	a_hld: assert property (p_hld) else $error("hold too big");
	a_sta: assert property (p_sta) else $error("bad status");
	a_rst: assert property (p_rst) else $error("reset state");
	c_err: cover property (pslverr_o);
	c_on: cover property ($rose(port_o));
	c_off: cover property ($fell(port_o));
endmodule // ddc_chk
bind ddc_drive_ctrl ddc_chk ddc_chk_i (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .pready_o,
	.pslverr_o, .port_o, .paddr_i, .prdata_o);

// >>> tb/digital_output_drive_control_tb_top.sv
// Bench for the drive block.
// Needs ddc_map.vh.
`timescale 1ns/1ps
`include "ddc_map.vh"
module digital_output_drive_control_tb_top;
	logic        clk = 0, rst = 1, ps = 0, pe = 0, pw = 0, lv = 0, e;
	logic [11:0] pa = 0;
	logic [31:0] wd = 0, rd;
	wire  [31:0] prd;
	wire         rdy, err, port, on;
	int          fails = 0, checked = 0, cyc = 0;
	initial forever #25 clk = ~clk;
	// Short second keeps pulses tens of cycles
	ddc_drive_ctrl #(.TICK_CYC(25'd20)) ddc_drive_ctrl_i (.core_clk_i(clk), .rst_i(rst), .psel_i(ps),
		.penable_i(pe), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(wd), .prdata_o(prd), .pready_o(rdy),
		.pslverr_o(err), .link_value_i(lv), .port_o(port));
	ddc_load ddc_load_i (.core_clk_i(clk), .drive_i(port), .on_o(on));
	task chk(input logic [31:0] g, x);
		checked++;
		if (g !== x) begin
			fails++;
			$display("unexpected %0t %h %h", $time, g, x);
		end
	endtask
	task print_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 2000) begin
			fails++;
			print_verdict;
		end
	end
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		ps <= 1;
		pw <= w;
		pa <= a;
		wd <= d;
		@(posedge clk) pe <= 1;
		do @(posedge clk); while (rdy !== 1);
		rd = prd;
		e = err;
		ps <= 0;
		pe <= 0;
		@(posedge clk);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] x);
		acc(0, a, 0);
		chk(rd, x);
	endtask
	task pc(input int n, input logic x);
		repeat (n) @(posedge clk);
		chk({31'h0, on}, {31'h0, x});
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rdc(`DDC_OFF_CTRL, 0);
		rdc(`DDC_OFF_CMD, 0);
		acc(0, 12'h0FC, 0);
		chk({31'h0, e}, 1);
		acc(1, `DDC_OFF_HOLD, 32'h003F_FFFF);
		rdc(`DDC_OFF_HOLD, 32'h001E_8480);
		acc(1, `DDC_OFF_CTRL, 1);
		lv <= 1;
		pc(3, 1);
		acc(1, `DDC_OFF_CTRL, 5);
		pc(3, 0);
		acc(1, `DDC_OFF_CTRL, 4);
		pc(3, 1);
		acc(1, `DDC_OFF_CTRL, 0);
		acc(1, `DDC_OFF_HOLD, 2);
		acc(1, `DDC_OFF_CMD, 1);
		pc(22, 1);
		acc(1, `DDC_OFF_CMD, 2);
		pc(3, 1);
		acc(1, `DDC_OFF_CMD, 1);
		rdc(`DDC_OFF_REM, 2);
		pc(20, 1);
		pc(25, 0);
		acc(1, `DDC_OFF_HOLD, 0);
		lv <= 0;
		acc(1, `DDC_OFF_CTRL, 1);
		acc(1, `DDC_OFF_CMD, 1);
		pc(60, 1);
		rdc(`DDC_OFF_STAT, 7);
		acc(1, `DDC_OFF_CMD, 2);
		lv <= 1;
		pc(3, 0);
		acc(1, `DDC_OFF_CMD, 4);
		pc(3, 1);
		rdc(`DDC_OFF_STAT, 5);
		print_verdict;
	end
endmodule // digital_output_drive_control_tb_top
